// >>> src/lsc_pkg.sv
// lsc_pkg: shared constants and types of the light sensor control block
package lsc_pkg;
   // ======================================================
   // timing
   localparam int CLK_MHZ = 100;
   localparam int INTEG_SHORT_US = 13700;
   localparam int INTEG_MID_US = 101000;
   localparam int INTEG_LONG_US = 402000;
   localparam int INTEG_SHORT_CYC = INTEG_SHORT_US * CLK_MHZ;
   localparam int INTEG_MID_CYC = INTEG_MID_US * CLK_MHZ;
   localparam int INTEG_LONG_CYC = INTEG_LONG_US * CLK_MHZ;
   localparam int TMR_W = 26;
   // ======================================================
   // register offsets
   localparam logic [3:0] REG_POWER = 4'h0;
   localparam logic [3:0] REG_TIMING = 4'h1;
   localparam logic [3:0] REG_LOW_LSB = 4'h2;
   localparam logic [3:0] REG_LOW_MSB = 4'h3;
   localparam logic [3:0] REG_HIGH_LSB = 4'h4;
   localparam logic [3:0] REG_HIGH_MSB = 4'h5;
   localparam logic [3:0] REG_IRQ = 4'h6;
   localparam logic [3:0] REG_CH0_LSB = 4'hC;
   localparam logic [3:0] REG_CH0_MSB = 4'hD;
   // ======================================================
   // fields
   localparam int CMD_SEL_BIT = 7;
   localparam int CMD_CLEAR_BIT = 6;
   localparam int CMD_WORD_BIT = 5;
   localparam int CMD_PTR_MSB = 3;
   localparam int POWER_MSB = 1;
   localparam int GAIN_BIT = 4;
   localparam int MANUAL_BIT = 3;
   localparam int INTEG_MSB = 1;
   localparam int MODE_MSB = 5;
   localparam int MODE_LSB = 4;
   localparam int PERSIST_MSB = 3;
   localparam logic [7:0] TIMING_MASK = 8'h1B;
   localparam logic [7:0] IRQ_MASK = 8'h3F;
   localparam logic [1:0] POWER_UP = 2'h3;
   localparam logic [1:0] INTEG_SHORT = 2'h0;
   localparam logic [1:0] INTEG_MID = 2'h1;
   localparam logic [1:0] INTEG_MANUAL = 2'h3;
   localparam logic [1:0] MODE_LEVEL = 2'h1;
   localparam logic [3:0] PERSIST_MAX = 4'hF;
   // ======================================================
   // reset and idle values
   localparam logic [3:0] PTR_RST = 4'h0;
   localparam logic [1:0] POWER_RST = 2'h0;
   localparam logic [7:0] TIMING_RST = 8'h02;
   localparam logic [15:0] THR_RST = 16'h0000;
   localparam logic [7:0] IRQ_RST = 8'h00;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   // ======================================================
   // link to register side operations
   typedef enum logic [1:0] {
      LSC_OP_START = 2'b00,
      LSC_OP_WR = 2'b01,
      LSC_OP_RD = 2'b10
   } lsc_op_e;
endpackage

// >>> src/lsc_xfer_if.sv
// lsc_xfer_if: toggle handshake between the link engine and the register side
`timescale 1ns/1ps
`default_nettype none
interface lsc_xfer_if;
   logic req_tgl;
   lsc_pkg::lsc_op_e op;
   logic [7:0] wdata;
   logic ack_tgl;
   logic [7:0] rdata;
   modport link (output req_tgl, output op, output wdata, input ack_tgl, input rdata);
   modport regs (input req_tgl, input op, input wdata, output ack_tgl, output rdata);
endinterface
`default_nettype wire

// >>> src/lsc_i2c_link.sv
// lsc_i2c_link: two-wire serial slave engine on the link clock
`timescale 1ns/1ps
`default_nettype none
module lsc_i2c_link #(
   parameter logic [6:0] SLAVE_ADDR = 7'h29
) (
   input wire logic clk_link,
   input wire logic rst,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   lsc_xfer_if.link xf
);
   typedef enum logic [2:0] {
      LK_IDLE = 3'b000,
      LK_ADDR = 3'b001,
      LK_ADDR_ACK = 3'b010,
      LK_WR = 3'b011,
      LK_WR_ACK = 3'b100,
      LK_RD = 3'b101,
      LK_RD_ACK = 3'b110
   } lsc_lk_e;

   typedef struct packed {
      logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
      lsc_lk_e st;
      logic [3:0] bits;
      logic [7:0] sh;
      logic rw, acked, drv_low, oe_n;
      logic req_tgl;
      lsc_pkg::lsc_op_e op;
      logic [7:0] wdata;
      logic ack_m, ack_s;
   } lsc_lk_s;

   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam lsc_lk_s LK_RST = '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1,
      sda_s: 1'b1, sda_p: 1'b1, oe_n: 1'b1, st: LK_IDLE, op: lsc_pkg::LSC_OP_START, default: '0};

   lsc_lk_s q, n;
   logic rise, fall, start, stop;
   logic [7:0] rd_byte;

   always_comb begin
      n = q;
      n.scl_m = scl_i;
      n.scl_s = q.scl_m;
      n.scl_p = q.scl_s;
      n.sda_m = sda_i;
      n.sda_s = q.sda_m;
      n.sda_p = q.sda_s;
      n.ack_m = xf.ack_tgl;
      n.ack_s = q.ack_m;
      rise = q.scl_s & ~q.scl_p;
      fall = ~q.scl_s & q.scl_p;
      start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
      stop = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
      // a byte not yet answered by the register side reads as released bus
      rd_byte = (q.ack_s == q.req_tgl) ? xf.rdata : lsc_pkg::IDLE_BYTE;
      if (start) begin
         n.st = LK_ADDR;
         n.bits = '0;
         n.drv_low = 1'b0;
      end else if (stop) begin
         n.st = LK_IDLE;
         n.drv_low = 1'b0;
      end else if (rise) begin
         case (q.st)
            LK_ADDR, LK_WR: begin
               n.sh = {q.sh[6:0], q.sda_s};
               n.bits = q.bits + 4'h1;
            end
            LK_RD: n.bits = q.bits + 4'h1;
            LK_RD_ACK: begin
               n.acked = ~q.sda_s;
               if (!q.sda_s) begin
                  n.req_tgl = ~q.req_tgl;
                  n.op = lsc_pkg::LSC_OP_RD;
               end
            end
            default: n.st = q.st;
         endcase
      end else if (fall) begin
         case (q.st)
            LK_ADDR: if (q.bits == BYTE_BITS) begin
               if (q.sh[7:1] == SLAVE_ADDR) begin
                  n.drv_low = 1'b1;
                  n.rw = q.sh[0];
                  n.st = LK_ADDR_ACK;
                  n.req_tgl = ~q.req_tgl;
                  n.op = lsc_pkg::LSC_OP_START;
                  n.wdata = {7'h00, q.sh[0]};
               end else begin
                  n.st = LK_IDLE;
               end
            end
            LK_ADDR_ACK: begin
               n.bits = '0;
               n.sh = rd_byte;
               n.drv_low = q.rw & ~rd_byte[7];
               n.st = q.rw ? LK_RD : LK_WR;
            end
            LK_WR: if (q.bits == BYTE_BITS) begin
               n.drv_low = 1'b1;
               n.st = LK_WR_ACK;
               n.req_tgl = ~q.req_tgl;
               n.op = lsc_pkg::LSC_OP_WR;
               n.wdata = q.sh;
            end
            LK_WR_ACK: begin
               n.drv_low = 1'b0;
               n.bits = '0;
               n.st = LK_WR;
            end
            LK_RD: begin
               if (q.bits == BYTE_BITS) begin
                  n.drv_low = 1'b0;
                  n.st = LK_RD_ACK;
               end else begin
                  n.drv_low = ~q.sh[~q.bits[2:0]];
               end
            end
            LK_RD_ACK: begin
               n.bits = '0;
               n.sh = rd_byte;
               n.drv_low = q.acked & ~rd_byte[7];
               n.st = q.acked ? LK_RD : LK_IDLE;
            end
            default: n.st = q.st;
         endcase
      end
      // enable kept in its own flop so the pin sees no gate after the register
      n.oe_n = ~n.drv_low;
   end

   always_ff @(posedge clk_link or posedge rst) begin
      if (rst) begin
         q <= LK_RST;
      end else begin
         q <= n;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_n = q.oe_n;
   assign xf.req_tgl = q.req_tgl;
   assign xf.op = q.op;
   assign xf.wdata = q.wdata;
endmodule
`default_nettype wire

// >>> src/lsc_core.sv
// lsc_core: command, control, integration timing and threshold interrupt logic
`timescale 1ns/1ps
`default_nettype none
module lsc_core #(
   parameter logic [6:0] SLAVE_ADDR = 7'h29,
   parameter int INTEG_SHORT_CYC = lsc_pkg::INTEG_SHORT_CYC,
   parameter int INTEG_MID_CYC = lsc_pkg::INTEG_MID_CYC,
   parameter int INTEG_LONG_CYC = lsc_pkg::INTEG_LONG_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_link,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   input wire logic [15:0] ch0_result,
   input wire logic conv_done,
   output logic adc_powered,
   output logic adc_gain_high,
   output logic adc_integrate,
   output logic int_n
);
   // ======================================================
   // link engine
   lsc_xfer_if xf ();

   lsc_i2c_link #(.SLAVE_ADDR(SLAVE_ADDR)) u_link (
      .clk_link(clk_link),
      .rst(rst),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe_n(sda_oe_n),
      .xf(xf)
   );

   // ======================================================
   // state
   typedef struct packed {
      logic req_m, req_s, req_p;
      logic ack_tgl;
      logic [7:0] rdata;
      logic [3:0] ptr;
      logic word;
      logic first;
      logic didx;
      logic [1:0] power;
      logic [7:0] timing;
      logic [15:0] lo;
      logic [15:0] hi;
      logic [7:0] icfg;
      logic pend;
      logic [3:0] pcnt;
      logic [15:0] ch0;
      logic [lsc_pkg::TMR_W-1:0] tmr;
      logic integ;
      logic pwr_o;
      logic gain_o;
      logic int_n;
   } lsc_sys_s;

   localparam lsc_sys_s SYS_RST = '{
      ptr: lsc_pkg::PTR_RST,
      power: lsc_pkg::POWER_RST,
      timing: lsc_pkg::TIMING_RST,
      lo: lsc_pkg::THR_RST,
      hi: lsc_pkg::THR_RST,
      icfg: lsc_pkg::IRQ_RST,
      int_n: 1'b1,
      default: '0
   };

   lsc_sys_s q, n;
   logic ev, clr, is_cmd, out_win, fire, irq_en;
   logic [3:0] wa;
   logic [3:0] nxt;
   logic [1:0] integ_sel;
   logic [lsc_pkg::TMR_W-1:0] lim;

   function automatic logic [7:0] lsc_rd(input lsc_sys_s s, input logic [3:0] a);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         lsc_pkg::REG_POWER: r = {6'h00, s.power};
         lsc_pkg::REG_TIMING: r = s.timing;
         lsc_pkg::REG_LOW_LSB: r = s.lo[7:0];
         lsc_pkg::REG_LOW_MSB: r = s.lo[15:8];
         lsc_pkg::REG_HIGH_LSB: r = s.hi[7:0];
         lsc_pkg::REG_HIGH_MSB: r = s.hi[15:8];
         lsc_pkg::REG_IRQ: r = s.icfg;
         lsc_pkg::REG_CH0_LSB: r = s.ch0[7:0];
         lsc_pkg::REG_CH0_MSB: r = s.ch0[15:8];
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // ======================================================
   // next state
   always_comb begin
      n = q;
      n.req_m = xf.req_tgl;
      n.req_s = q.req_m;
      n.req_p = q.req_s;
      ev = q.req_s ^ q.req_p;
      clr = 1'b0;
      // only the first byte after the address may be a command
      is_cmd = q.first & xf.wdata[lsc_pkg::CMD_SEL_BIT];
      wa = q.word ? (q.ptr + {3'h0, q.didx}) : q.ptr;
      if (ev) begin
         n.ack_tgl = ~q.ack_tgl;
         case (xf.op)
            lsc_pkg::LSC_OP_START: begin
               n.first = 1'b1;
               n.didx = 1'b0;
               if (xf.wdata[0]) begin
                  n.rdata = lsc_rd(q, q.ptr);
                  n.didx = 1'b1;
               end
            end
            lsc_pkg::LSC_OP_WR: begin
               n.first = 1'b0;
               if (is_cmd) begin
                  n.ptr = xf.wdata[lsc_pkg::CMD_PTR_MSB:0];
                  n.word = xf.wdata[lsc_pkg::CMD_WORD_BIT];
                  clr = xf.wdata[lsc_pkg::CMD_CLEAR_BIT];
                  n.didx = 1'b0;
               end else begin
                  n.didx = 1'b1;
                  case (wa)
                     lsc_pkg::REG_POWER: n.power = xf.wdata[lsc_pkg::POWER_MSB:0];
                     lsc_pkg::REG_TIMING: n.timing = xf.wdata & lsc_pkg::TIMING_MASK;
                     lsc_pkg::REG_LOW_LSB: n.lo[7:0] = xf.wdata;
                     lsc_pkg::REG_LOW_MSB: n.lo[15:8] = xf.wdata;
                     lsc_pkg::REG_HIGH_LSB: n.hi[7:0] = xf.wdata;
                     lsc_pkg::REG_HIGH_MSB: n.hi[15:8] = xf.wdata;
                     lsc_pkg::REG_IRQ: n.icfg = xf.wdata & lsc_pkg::IRQ_MASK;
                     default: n.didx = 1'b1;
                  endcase
               end
            end
            lsc_pkg::LSC_OP_RD: begin
               n.rdata = lsc_rd(q, wa);
               n.didx = 1'b1;
            end
            default: n.first = 1'b0;
         endcase
      end

      // integration timing of the converter, one period counter
      integ_sel = q.timing[lsc_pkg::INTEG_MSB:0];
      case (integ_sel)
         lsc_pkg::INTEG_SHORT: lim = lsc_pkg::TMR_W'(INTEG_SHORT_CYC);
         lsc_pkg::INTEG_MID: lim = lsc_pkg::TMR_W'(INTEG_MID_CYC);
         default: lim = lsc_pkg::TMR_W'(INTEG_LONG_CYC);
      endcase
      if (q.power != lsc_pkg::POWER_UP) begin
         n.tmr = '0;
         n.integ = 1'b0;
      end else if (integ_sel == lsc_pkg::INTEG_MANUAL) begin
         n.tmr = '0;
         n.integ = q.timing[lsc_pkg::MANUAL_BIT];
      end else if (q.tmr >= lim - lsc_pkg::TMR_W'(1)) begin
         // one idle cycle marks the end of each period
         n.tmr = '0;
         n.integ = 1'b0;
      end else begin
         n.tmr = q.tmr + lsc_pkg::TMR_W'(1);
         n.integ = 1'b1;
      end

      // threshold interrupt; a conversion in the clear cycle still counts
      out_win = (ch0_result <= q.lo) || (ch0_result > q.hi);
      nxt = !out_win ? 4'h0 :
         (q.pcnt == lsc_pkg::PERSIST_MAX) ? q.pcnt : q.pcnt + 4'h1;
      fire = (q.icfg[lsc_pkg::PERSIST_MSB:0] == 4'h0) ||
         (out_win && nxt >= q.icfg[lsc_pkg::PERSIST_MSB:0]);
      irq_en = q.icfg[lsc_pkg::MODE_MSB:lsc_pkg::MODE_LSB] == lsc_pkg::MODE_LEVEL;
      if (clr) begin
         n.pend = 1'b0;
         n.pcnt = 4'h0;
      end
      if (conv_done) begin
         n.ch0 = ch0_result;
         n.pcnt = nxt;
         if (fire && irq_en) begin
            n.pend = 1'b1;
         end
      end

      n.pwr_o = n.power == lsc_pkg::POWER_UP;
      n.gain_o = n.timing[lsc_pkg::GAIN_BIT];
      n.int_n = ~n.pend;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= SYS_RST;
      end else begin
         q <= n;
      end
   end

   assign xf.ack_tgl = q.ack_tgl;
   assign xf.rdata = q.rdata;
   assign adc_powered = q.pwr_o;
   assign adc_gain_high = q.gain_o;
   assign adc_integrate = q.integ;
   assign int_n = q.int_n;

   // ======================================================
   // assertions
   logic wr_ev, cmd_ev;
   assign wr_ev = ev && (xf.op == lsc_pkg::LSC_OP_WR);
   assign cmd_ev = wr_ev && is_cmd;

   a_ptr_load: assert property (@(posedge clk_sys) disable iff (rst)
      cmd_ev |=> q.ptr == $past(xf.wdata[3:0]))
      else $error("pointer not loaded from command byte");

   a_word_flag: assert property (@(posedge clk_sys) disable iff (rst)
      cmd_ev |=> q.word == $past(xf.wdata[5]))
      else $error("word flag not taken from command byte");

   a_clear_release: assert property (@(posedge clk_sys) disable iff (rst)
      (cmd_ev && xf.wdata[6] && !conv_done) |=> ##1 int_n)
      else $error("clear bit did not release interrupt");

   a_power_readback: assert property (@(posedge clk_sys) disable iff (rst)
      (ev && xf.op == lsc_pkg::LSC_OP_START && xf.wdata[0] && q.ptr == lsc_pkg::REG_POWER
       && q.power == lsc_pkg::POWER_UP) |=> q.rdata == 8'h03)
      else $error("power register did not read back 03h");

   a_power_up: assert property (@(posedge clk_sys) disable iff (rst)
      (wr_ev && !is_cmd && wa == lsc_pkg::REG_POWER && xf.wdata == 8'h03) |=> ##1 adc_powered)
      else $error("write of 03h did not power up");

   a_low_window: assert property (@(posedge clk_sys) disable iff (rst)
      (conv_done && irq_en && q.icfg[3:0] == 4'h1 && ch0_result <= q.lo) |=> ##1 !int_n)
      else $error("result at or below low limit did not interrupt");

   a_high_window: assert property (@(posedge clk_sys) disable iff (rst)
      (conv_done && irq_en && q.icfg[3:0] == 4'h1 && ch0_result > q.hi) |=> ##1 !int_n)
      else $error("result above high limit did not interrupt");

   a_every_cycle: assert property (@(posedge clk_sys) disable iff (rst)
      (conv_done && irq_en && q.icfg[3:0] == 4'h0) |=> ##1 !int_n)
      else $error("persistence zero did not interrupt");

   a_inside_reset: assert property (@(posedge clk_sys) disable iff (rst)
      (conv_done && !out_win) |=> q.pcnt == 4'h0)
      else $error("counter not cleared inside window");

   a_int_holds: assert property (@(posedge clk_sys) disable iff (rst)
      (!int_n && !clr) |=> !int_n)
      else $error("level interrupt released without clear");

   a_disabled_quiet: assert property (@(posedge clk_sys) disable iff (rst)
      (int_n && !irq_en) |=> int_n)
      else $error("interrupt raised while disabled");

   a_manual_run: assert property (@(posedge clk_sys) disable iff (rst)
      (q.power == lsc_pkg::POWER_UP && integ_sel == lsc_pkg::INTEG_MANUAL)
      |=> adc_integrate == $past(q.timing[3]))
      else $error("manual bit did not steer integration");

   // outputs are registered copies of the fields; a stale copy would mislead the converter
   a_power_follow: assert property (@(posedge clk_sys) disable iff (rst)
      adc_powered == (q.power == lsc_pkg::POWER_UP))
      else $error("power output does not follow power field");

   a_power_down_idle: assert property (@(posedge clk_sys) disable iff (rst)
      (q.power != lsc_pkg::POWER_UP) |=> !adc_integrate)
      else $error("integration running while powered down");

   a_gain_follow: assert property (@(posedge clk_sys) disable iff (rst)
      adc_gain_high == q.timing[lsc_pkg::GAIN_BIT])
      else $error("gain output does not follow timing bit");

   a_period_end: assert property (@(posedge clk_sys) disable iff (rst)
      (q.power == lsc_pkg::POWER_UP && integ_sel != lsc_pkg::INTEG_MANUAL
       && q.tmr == lim - lsc_pkg::TMR_W'(1)) |=> !adc_integrate)
      else $error("integration period did not end");

   a_persist_wait: assert property (@(posedge clk_sys) disable iff (rst)
      (conv_done && int_n && q.icfg[3:0] != 4'h0 && nxt < q.icfg[3:0]) |=> int_n)
      else $error("interrupt before persistence count reached");

   a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
      q.icfg[7:6] == 2'b00 && q.timing[7:5] == 3'b000)
      else $error("reserved bits stored");

   // a pointer that moved on data bytes would scatter word writes
   a_ptr_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !cmd_ev |=> q.ptr == $past(q.ptr))
      else $error("pointer moved without command byte");

   c_level_irq: cover property (@(posedge clk_sys) disable iff (rst)
      int_n ##1 !int_n ##[1:1000] int_n);
   c_word_write: cover property (@(posedge clk_sys) disable iff (rst)
      (cmd_ev && xf.wdata[5]) ##[1:1000] (wr_ev && q.didx));
   c_word_read: cover property (@(posedge clk_sys) disable iff (rst)
      (ev && xf.op == lsc_pkg::LSC_OP_RD && q.word));
   c_persist_count: cover property (@(posedge clk_sys) disable iff (rst)
      conv_done && q.pcnt == 4'h2 && out_win);
endmodule
`default_nettype wire

// >>> test/lsc_i2c_master.sv
// lsc_i2c_master: two-wire bus master model for the sensor link
`timescale 1ns/1ps
`default_nettype none
module lsc_i2c_master (
   input wire logic clk_sys,
   input wire logic sda_in,
   output logic scl,
   output logic sda_rel
);
   // half period of the serial clock in clk_sys cycles; raise it for a slow master
   int hc = 20;
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // ======================================================
   // framing: the start and stop edges of sda come while scl is high
   task automatic start();
      sda_rel <= 1'b1;
      w(hc);
      scl <= 1'b1;
      w(hc);
      sda_rel <= 1'b0;
      w(hc);
      scl <= 1'b0;
      w(hc / 4);
   endtask
   task automatic stop();
      sda_rel <= 1'b0;
      w(hc);
      scl <= 1'b1;
      w(hc);
      sda_rel <= 1'b1;
      w(hc);
   endtask
   // ======================================================
   // eight bits msb first and the acknowledge slot; a 1 releases the line
   task automatic xbyte(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda_rel <= tx[i];
         w(hc);
         scl <= 1'b1;
         w(hc);
         rx[i] = sda_in;
         scl <= 1'b0;
         // data moves hc / 4 cycles, a quarter of the half period, after the fall, never with it
         w(hc / 4);
      end
   endtask
endmodule
`default_nettype wire

// >>> test/lsc_core_tb.sv
// lsc_core_tb: self-checking bench for the light sensor control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
   $display("Error %s expected %h seen %h", nm, exp, got); end end
module lsc_core_tb;
   logic clk_sys;
   logic clk_link;
   logic rst = 1'b1;
   logic conv_done = 1'b0;
   logic [15:0] ch0_result = 16'h0000;
   wire scl;
   wire sda_rel;
   wire sda_o;
   wire sda_oe_n;
   wire adc_powered;
   wire adc_gain_high;
   wire adc_integrate;
   wire int_n;
   // pull-up: low only while some party pulls
   wire sda = sda_rel & (sda_oe_n | sda_o);
   int error_cnt = 0;
   int n_tests = 0;
   logic [8:0] rx;
   logic [7:0] rq[$];
   lsc_core #(.INTEG_SHORT_CYC(50), .INTEG_MID_CYC(100), .INTEG_LONG_CYC(200)) i_lsc_core (
      .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n), .ch0_result(ch0_result), .conv_done(conv_done),
      .adc_powered(adc_powered), .adc_gain_high(adc_gain_high),
      .adc_integrate(adc_integrate), .int_n(int_n));
   lsc_i2c_master i_lsc_i2c_master (.clk_sys(clk_sys), .sda_in(sda), .scl(scl),
      .sda_rel(sda_rel));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      clk_link = 1'b0;
      #3.3;
      forever #7.5 clk_link = ~clk_link;
   end
   // ======================================================
   // bus helpers
   task automatic wr(input logic [7:0] b[$]);
      i_lsc_i2c_master.start();
      i_lsc_i2c_master.xbyte({8'h52, 1'b1}, rx);
      `CHK("addr ack", 1'b0, rx[0])
      foreach (b[i]) begin
         i_lsc_i2c_master.xbyte({b[i], 1'b1}, rx);
         `CHK("data ack", 1'b0, rx[0])
      end
      i_lsc_i2c_master.stop();
   endtask
   // reads n bytes from the stored pointer, nack on the last
   task automatic rd(input int n);
      rq = {};
      i_lsc_i2c_master.start();
      i_lsc_i2c_master.xbyte({8'h53, 1'b1}, rx);
      for (int i = 0; i < n; i++) begin
         i_lsc_i2c_master.xbyte({8'hFF, i == n - 1}, rx);
         rq.push_back(rx[8:1]);
      end
      i_lsc_i2c_master.stop();
   endtask
   task automatic conv(input logic [15:0] v, input logic exp);
      ch0_result <= v;
      conv_done <= 1'b1;
      @(posedge clk_sys);
      conv_done <= 1'b0;
      repeat (3) @(posedge clk_sys);
      `CHK("int_n", exp, int_n)
   endtask
   // length of one high phase of the integration strobe
   task automatic integ(input logic [7:0] tv, input int exp);
      int n = 0;
      wr({tv});
      for (int i = 0; i < 500 && adc_integrate !== 1'b0; i++) @(posedge clk_sys);
      for (int i = 0; i < 500 && adc_integrate !== 1'b1; i++) @(posedge clk_sys);
      while (adc_integrate === 1'b1 && n < 500) begin
         n++;
         @(posedge clk_sys);
      end
      `CHK("integ len", exp, n)
   endtask
   // ======================================================
   // scenarios
   task automatic t_reset();
      `CHK("int_n", 1'b1, int_n)
      `CHK("powered", 1'b0, adc_powered)
      rd(1);
      `CHK("power rst", 8'h00, rq[0])
      wr({8'h81});
      rd(1);
      `CHK("timing rst", 8'h02, rq[0])
      wr({8'hA2});
      rd(2);
      `CHK("low rst", 16'h0000, {rq[1], rq[0]})
      wr({8'hA4});
      rd(2);
      `CHK("high rst", 16'h0000, {rq[1], rq[0]})
      wr({8'h86});
      rd(1);
      `CHK("cfg rst", 8'h00, rq[0])
   endtask
   task automatic t_power();
      wr({8'h80, 8'h03}); // command byte has bit 7 set
      `CHK("powered", 1'b1, adc_powered)
      rd(1);
      `CHK("power rd", 8'h03, rq[0])
      wr({8'h00});
      `CHK("powered", 1'b0, adc_powered)
      `CHK("integ off", 1'b0, adc_integrate)
      wr({8'h03});
   endtask
   task automatic t_timing();
      wr({8'h81, 8'hF4});
      `CHK("gain", 1'b1, adc_gain_high)
      rd(1);
      `CHK("timing rd", 8'h10, rq[0])
      integ(8'h00, 49);
      integ(8'h01, 99);
      integ(8'h02, 199);
      integ(8'h08, 49); // manual bit ignored outside manual
      wr({8'h0B});
      repeat (300) @(posedge clk_sys);
      `CHK("manual on", 1'b1, adc_integrate)
      `CHK("gain", 1'b0, adc_gain_high)
      wr({8'h03});
      `CHK("manual off", 1'b0, adc_integrate)
   endtask
   task automatic t_window();
      wr({8'hA2, 8'h00, 8'h10}); // paired word write
      rd(2);
      `CHK("low thr", 16'h1000, {rq[1], rq[0]})
      wr({8'hA4, 8'h00, 8'h20});
      wr({8'h86, 8'h11});
      conv(16'h1001, 1'b1);
      conv(16'h2000, 1'b1);
      conv(16'h1000, 1'b0);
      conv(16'h1500, 1'b0);
      wr({8'hC6});
      `CHK("cleared", 1'b1, int_n)
      conv(16'h2001, 1'b0);
      wr({8'hC6});
      rd(1);
      `CHK("cfg rd", 8'h11, rq[0])
   endtask
   task automatic t_persist();
      wr({8'h86, 8'h13});
      conv(16'h0000, 1'b1);
      conv(16'h0000, 1'b1);
      conv(16'h1800, 1'b1);
      conv(16'h0000, 1'b1);
      conv(16'h0000, 1'b1);
      conv(16'hFFFF, 1'b0);
      wr({8'hC0});
      conv(16'h0000, 1'b1);
      wr({8'h86, 8'h10});
      conv(16'h1800, 1'b0);
      wr({8'hC6, 8'h00});
      conv(16'h0000, 1'b1);
      wr({8'h20});
      conv(16'h0000, 1'b1);
      wr({8'h86, 8'hFF});
      rd(1);
      `CHK("cfg mask", 8'h3F, rq[0])
      conv(16'h0000, 1'b1);
   endtask
   // slow master, unmapped place reads zero and ignores writes
   task automatic t_ptr();
      i_lsc_i2c_master.hc = 40;
      wr({8'h87, 8'h55});
      rd(1);
      `CHK("unmapped", 8'h00, rq[0])
      conv(16'h1234, 1'b1);
      wr({8'hAC});
      rd(2);
      `CHK("ch0 rd", 16'h1234, {rq[1], rq[0]})
   endtask
   // ======================================================
   // sequence and verdict
   task automatic finish_test();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (10) @(posedge clk_sys);
      t_reset();
      t_power();
      t_timing();
      t_window();
      t_persist();
      t_ptr();
      finish_test();
   end
   // the sequence needs about 49k cycles
   initial begin
      repeat (95000) @(posedge clk_sys);
      error_cnt++;
      finish_test();
   end
endmodule
`default_nettype wire
